// ### core/bise_regs.vh
`ifndef BISE_REGS_VH
`define BISE_REGS_VH
// What this block does
// - a far jump is two words: 1110 1111 with target bits 7:0, then 1111 with bits 19:8.
// - a far jump loads the 20-bit target into program counter bits 20:1 and leaves flags alone.
// - a far jump takes two cycles, low byte read in phase 2, high bits and pc write in phase 4, then a no-op cycle.
// - file increment (0010 10da) adds one to the file operand and updates all five flags.
// - destination bit 0 sends the result to the accumulator, 1 writes it back to the file register.
// - access bit 0 picks the access bank, 1 uses the bank selector for the upper address bits.
// - with access bit 0, extended set on and address up to 95, the address is an offset from the index.
// - literal minus accumulator (0000 1000) writes literal minus accumulator to the accumulator in one cycle with flags.
// - file minus accumulator (0101 11da) subtracts the accumulator from the file operand, to the chosen destination, with flags.

// ****************
// opcodes
// ****************
`define BISE_OP_JUMP1 8'hef
`define BISE_OP_JUMP2 4'hf
`define BISE_OP_INC 6'h0a
`define BISE_OP_SUBL 8'h08
`define BISE_OP_SUBF 6'h17

// ****************
// field positions
// ****************
`define BISE_D_BIT 9
`define BISE_A_BIT 8
`define BISE_IDX_MAX 8'h5f
`define BISE_ACC_SPLIT 8'h80
`define BISE_ACC_HI_BANK 4'hf

// ****************
// phases
// ****************
`define BISE_Q1 2'h0
`define BISE_Q2 2'h1
`define BISE_Q3 2'h2
`define BISE_Q4 2'h3
`endif

// ### core/bise_alu.v
`include "bise_regs.vh"
module bise_alu (
    a,
    b,
    sub,
    res,
    c,
    dc,
    n,
    ov,
    z
);
    input wire [7:0] a;
    input wire [7:0] b;
    input wire sub;
    output wire [7:0] res;
    output wire c;
    output wire dc;
    output wire n;
    output wire ov;
    output wire z;
    wire [7:0] bb;
    wire [8:0] sum;
    wire [4:0] low;
    // subtraction as a + ~b + 1, so carry set means no borrow
    // carry as not-borrow
    assign bb = sub ? ~b : b;
    assign sum = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
    assign low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    assign res = sum[7:0];
    assign c = sum[8];
    assign dc = low[4];
    assign n = sum[7];
    assign ov = (a[7] == bb[7]) && (sum[7] != a[7]);
    assign z = (sum[7:0] == 8'h00);
endmodule

// ### core/bise_core.v
`include "bise_regs.vh"
module bise_core (
    mclk,
    rstn,
    instr,
    ext_set_en,
    bank_selector,
    index_base,
    file_rdata,
    file_addr,
    file_wdata,
    file_we,
    acc,
    pc,
    flag_c,
    flag_half_byte_carry,
    flag_n,
    flag_signed_wrap_flag,
    flag_z,
    phase,
    skip_cycle
);
    input wire mclk;
    input wire rstn;
    input wire [15:0] instr;
    input wire ext_set_en;
    input wire [3:0] bank_selector;
    input wire [11:0] index_base;
    input wire [7:0] file_rdata;
    output reg [11:0] file_addr;
    output reg [7:0] file_wdata;
    output reg file_we;
    output reg [7:0] acc;
    output reg [20:0] pc;
    output reg flag_c;
    output reg flag_half_byte_carry;
    output reg flag_n;
    output reg flag_signed_wrap_flag;
    output reg flag_z;
    output reg [1:0] phase;
    output reg skip_cycle;

    // ****************
    // decode
    // ****************
    reg [15:0] ir;
    reg [7:0] low_k;
    reg [7:0] opnd;
    reg [7:0] res;
    reg [4:0] flg;
    reg is_inc;
    reg is_subl;
    reg is_subf;
    reg is_jump;
    wire [7:0] alu_a;
    wire [7:0] alu_b;
    wire alu_sub;
    wire [7:0] alu_res;
    wire a_c;
    wire a_dc;
    wire a_n;
    wire a_ov;
    wire a_z;
    reg [11:0] next_addr;

    // decoded strobes, the write-back choice and the jump target
    reg next_is_inc;
    reg next_is_subl;
    reg next_is_subf;
    reg next_is_jump;
    wire word2_ok;
    wire [20:0] next_pc;
    wire any_arith;
    wire dest_acc;

    always @* begin
        if (ir[`BISE_A_BIT]) begin
            next_addr = {bank_selector, ir[7:0]};
        end else if (ext_set_en && ir[7:0] <= `BISE_IDX_MAX) begin
            next_addr = index_base + {4'h0, ir[7:0]};
        end else if (ir[7:0] >= `BISE_ACC_SPLIT) begin
            next_addr = {`BISE_ACC_HI_BANK, ir[7:0]};
        end else begin
            next_addr = {4'h0, ir[7:0]};
        end
    end

    // ****************
    // opcode match
    // ****************
    // unknown opcodes decode to nothing and leave acc, flags and pc alone
    always @* begin
        next_is_inc = 1'b0;
        next_is_subl = 1'b0;
        next_is_subf = 1'b0;
        next_is_jump = 1'b0;
        if (!skip_cycle) begin
            next_is_inc = instr[15:10] == `BISE_OP_INC;
            next_is_subl = instr[15:8] == `BISE_OP_SUBL;
            next_is_subf = instr[15:10] == `BISE_OP_SUBF;
            next_is_jump = instr[15:8] == `BISE_OP_JUMP1;
        end
    end

    // ****************
    // operands and write-back
    // ****************
    // file data is taken at the q3 edge, one cycle after the address is set in q2,
    // so the file array behind file_rdata may be purely combinational
    assign alu_a = is_subl ? opnd : file_rdata;
    // increment reuses the adder with b fixed at one
    assign alu_b = is_inc ? 8'h01 : acc;
    assign alu_sub = !is_inc;
    assign any_arith = is_inc || is_subl || is_subf;
    assign dest_acc = is_subl || !ir[`BISE_D_BIT];

    // ****************
    // far jump target
    // ****************
    // second word prefix check
    assign word2_ok = is_jump && (instr[15:12] == `BISE_OP_JUMP2);
    assign next_pc = {instr[11:0], low_k, 1'b0};

    bise_alu u_alu (
        .a(alu_a),
        .b(alu_b),
        .sub(alu_sub),
        .res(alu_res),
        .c(a_c),
        .dc(a_dc),
        .n(a_n),
        .ov(a_ov),
        .z(a_z)
    );

    // ****************
    // four-phase sequencer
    // ****************
    // q1 decode, q2 read, q3 compute, q4 write
    always @(posedge mclk) begin
        if (!rstn) begin
            phase <= `BISE_Q1;
            ir <= 16'h0000;
            low_k <= 8'h00;
            opnd <= 8'h00;
            res <= 8'h00;
            flg <= 5'h00;
            is_inc <= 1'b0;
            is_subl <= 1'b0;
            is_subf <= 1'b0;
            is_jump <= 1'b0;
            skip_cycle <= 1'b0;
            file_addr <= 12'h000;
            file_wdata <= 8'h00;
            file_we <= 1'b0;
            acc <= 8'h00;
            pc <= 21'h000000;
            flag_c <= 1'b0;
            flag_half_byte_carry <= 1'b0;
            flag_n <= 1'b0;
            flag_signed_wrap_flag <= 1'b0;
            flag_z <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            file_we <= 1'b0;
            case (phase)
                `BISE_Q1: begin
                    ir <= instr;
                    is_inc <= next_is_inc;
                    is_subl <= next_is_subl;
                    is_subf <= next_is_subf;
                    is_jump <= next_is_jump;
                end
                `BISE_Q2: begin
                    if (is_jump) begin
                        low_k <= ir[7:0];
                    end
                    opnd <= ir[7:0];
                    file_addr <= next_addr;
                end
                `BISE_Q3: begin
                    // file operand sampled here
                    // the address went out at the q2 edge, so file_rdata has had a full
                    // cycle to settle; reading it one edge earlier would see the old address
                    res <= alu_res;
                    flg <= {a_c, a_dc, a_n, a_ov, a_z};
                end
                default: begin
                    // skip marks only the one cycle that follows a completed far jump
                    skip_cycle <= 1'b0;
                    if (word2_ok) begin
                        pc <= next_pc;
                        skip_cycle <= 1'b1;
                    end else if (any_arith) begin
                        flag_c <= flg[4];
                        flag_half_byte_carry <= flg[3];
                        flag_n <= flg[2];
                        flag_signed_wrap_flag <= flg[1];
                        flag_z <= flg[0];
                        if (dest_acc) begin
                            acc <= res;
                        end else begin
                            file_wdata <= res;
                            file_we <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// ### verif/bise_core_props.sv
module bise_props (
    input wire mclk,
    input wire rstn,
    input wire [15:0] instr,
    input wire [3:0] bank_selector,
    input wire [11:0] file_addr,
    input wire file_we,
    input wire [7:0] acc,
    input wire [20:0] pc,
    input wire flag_c,
    input wire flag_half_byte_carry,
    input wire flag_n,
    input wire flag_signed_wrap_flag,
    input wire flag_z,
    input wire [1:0] phase,
    input wire skip_cycle
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire [4:0] fl = {flag_c, flag_half_byte_carry, flag_n, flag_signed_wrap_flag, flag_z};
    sequence jmp;
        phase == 2'h0 && !skip_cycle && instr[15:8] == 8'hef ##3
        phase == 2'h3 && instr[15:12] == 4'hf;
    endsequence
    sequence subl;
        phase == 2'h0 && !skip_cycle && instr[15:8] == 8'h08;
    endsequence
    a_phase_steps: assert property ($past(rstn) |-> phase == $past(phase) + 2'h1)
        else $error("phase out of order");
    a_we_q4: assert property (file_we |-> $past(phase) == 2'h3)
        else $error("write outside q4");
    a_we_needs_dest: assert property (file_we |-> $past(instr[9], 4) &&
        $past(instr[15:10], 4) inside {6'h0a, 6'h17}) else $error("stray file write");
    a_jump_pc: assert property (jmp |=> pc ==
        {$past(instr[11:0]), $past(instr[7:0], 4), 1'b0}) else $error("jump target");
    a_jump_flags: assert property (jmp |=> fl == $past(fl))
        else $error("jump touched flags");
    a_jump_skip: assert property (jmp |=> skip_cycle ##4
        (acc == $past(acc, 4) && !file_we)) else $error("skip cycle acted");
    a_sublit_res: assert property (subl |-> ##4
        acc == $past(instr[7:0], 4) - $past(acc, 4) && flag_z == (acc == 8'h00) &&
        flag_n == acc[7] && flag_c == ($past(instr[7:0], 4) >= $past(acc, 4)))
        else $error("literal subtract");
    a_bank_addr: assert property (phase == 2'h2 && !skip_cycle && $past(instr[8], 2) &&
        $past(instr[15:10], 2) inside {6'h0a, 6'h17} |->
        file_addr == {bank_selector, $past(instr[7:0], 2)}) else $error("bank address");
endmodule

// ### verif/tb_top.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
$display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    reg mclk = 0, rstn = 0, ext_set_en = 1;
    reg [15:0] instr = 16'h0000;
    reg [3:0] bank_selector = 4'h3;
    reg [11:0] index_base = 12'h200;
    reg [7:0] mem [0:4095];
    wire [11:0] file_addr;
    wire [7:0] file_wdata, acc;
    wire [20:0] pc;
    wire [1:0] phase;
    wire file_we, flag_c, flag_half_byte_carry, flag_n, flag_signed_wrap_flag, flag_z, skip_cycle;
    wire [4:0] flags = {flag_c, flag_half_byte_carry, flag_n, flag_signed_wrap_flag, flag_z};
    wire [7:0] file_rdata = mem[file_addr];
    integer n_fail = 0, compares = 0, i;
    reg [7:0] eacc = 8'h00, r;
    reg [4:0] ef;
    always #10 mclk = ~mclk;
    always @(posedge mclk) if (file_we) mem[file_addr] <= file_wdata;
    bise_core u_dut (.mclk, .rstn, .instr, .ext_set_en, .bank_selector, .index_base,
        .file_rdata, .file_addr, .file_wdata, .file_we, .acc, .pc, .flag_c,
        .flag_half_byte_carry, .flag_n, .flag_signed_wrap_flag, .flag_z, .phase, .skip_cycle);
    // ****
    // tasks
    // ****
    task end_of_test;
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // nx is presented right after q4 so a jump's skip cycle really sees an opcode
    task run(input [15:0] w1, input [15:0] w2, input [15:0] nx);
        integer n;
        begin
            n = 0;
            while (phase !== 2'h3) begin
                @(negedge mclk);
                n++;
                if (n > 8) begin n_fail++; end_of_test; end
            end
            @(posedge mclk) instr <= w1;
            repeat (3) @(posedge mclk);
            instr <= w2;
            @(posedge mclk) instr <= nx;
            @(negedge mclk);
        end
    endtask
    task arith(input [15:0] w, input [7:0] a, input [7:0] b, input sub, input [11:0] ea);
        begin
            run(w, 16'h0000, 16'h0000);
            r = sub ? a - b : a + 8'h01;
            ef = sub ? {a >= b, a[3:0] >= b[3:0], r[7], a[7] != b[7] && r[7] != a[7], r == 0}
                : {a == 8'hff, a[3:0] == 4'hf, r[7], a == 8'h7f, r == 8'h00};
            `CHK(flags, ef)
            if (w[15:12] == 4'h0 || !w[9]) begin
                eacc = r;
                `CHK({file_we, acc}, {1'b0, r})
            end else begin
                `CHK({file_we, file_addr, file_wdata}, {1'b1, ea, r})
            end
        end
    endtask
    initial begin
        mem[12'hf90] = 8'hff;
        mem[12'h345] = 8'h7f;
        mem[12'h25f] = 8'h03;
        mem[12'h060] = 8'h90;
        mem[12'h05f] = 8'h0f;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        `CHK({acc, pc, flags}, 34'h0)
        for (i = 0; i < 4; i++) begin
            r = 32'h02020180 >> (24 - 8 * i);
            arith({8'h08, r}, r, eacc, 1'b1, 12'h0);
        end
        arith(16'h2a90, 8'hff, 8'h00, 1'b0, 12'hf90);
        arith(16'h2945, 8'h7f, 8'h00, 1'b0, 12'h345);
        arith(16'h5e5f, 8'h03, eacc, 1'b1, 12'h25f);
        arith(16'h5e60, 8'h90, eacc, 1'b1, 12'h060);
        // extended set off: low access addresses are direct again
        @(posedge mclk) ext_set_en <= 1'b0;
        arith(16'h2a5f, 8'h0f, 8'h00, 1'b0, 12'h05f);
        arith(16'h5c60, 8'h10, eacc, 1'b1, 12'h060);
        ef = flags;
        run(16'hefde, 16'hfabc, 16'h0855);
        `CHK({pc, flags, skip_cycle}, {20'habcde, 1'b0, ef, 1'b1})
        repeat (4) @(negedge mclk);
        `CHK(acc, eacc)
        end_of_test;
    end
endmodule
bind bise_core bise_props u_props (.mclk, .rstn, .instr, .bank_selector, .file_addr,
    .file_we, .acc, .pc, .flag_c, .flag_half_byte_carry, .flag_n, .flag_signed_wrap_flag,
    .flag_z, .phase, .skip_cycle);
